/* motion_pkg.sv */
/*
   shared types and constants of the motion command state machine:
   motion states, the synchroniser bit map of the monitor pins, state
   records and their reset values.
   assumes one clock (mclk) and one asynchronous active-low reset.
*/
package motion_pkg;

   // =========================================================
   // widths
   localparam int POS_W = 16;            // position word width
   localparam int MON_W = 5;             // number of monitor pins

   // =========================================================
   // bit positions of the monitor pins in the sync vector
   localparam int MON_UV_SHUTDOWN = 0;   // below undervoltage_shutdown_threshold
   localparam int MON_UV_WARNING  = 1;   // below undervoltage_warning_threshold
   localparam int MON_THERMAL     = 2;   // thermal shutdown comparator
   localparam int MON_ELEC_DEFECT = 3;   // short / open circuit detector
   localparam int MON_PUMP_FAIL   = 4;   // charge pump failure

   // =========================================================
   // motion states, gray along stopped-move-decel-halt-shutdown
   typedef enum logic [2:0] {
      ST_STOPPED             = 3'h0,
      ST_MOVING_TO_TARGET    = 3'h1,
      ST_DECELERATING_HALT   = 3'h3,
      ST_IMMEDIATE_HALT      = 3'h2,
      ST_SHUTDOWN            = 3'h6,
      ST_REFERENCE_SEARCH    = 3'h4
   } motion_state_t;

   // =========================================================
   // state records
   typedef struct packed {
      motion_state_t      state;          // current motion state
      logic [POS_W-1:0]   target;         // target_position_register
   } ctrl_state_t;

   typedef struct packed {
      logic [MON_W-1:0]   sync1;          // first synchroniser stage
      logic [MON_W-1:0]   sync2;          // second synchroniser stage
   } mon_state_t;

   // =========================================================
   // reset values; power-up lands in shutdown until status is read
   localparam logic [POS_W-1:0] TARGET_RESET = 16'h0000;
   localparam logic [MON_W-1:0] MON_RESET    = 5'h00;
   localparam ctrl_state_t CTRL_RESET = '{state: ST_SHUTDOWN, target: TARGET_RESET};
   localparam mon_state_t  MONS_RESET = '{sync1: MON_RESET, sync2: MON_RESET};

endpackage

/* fault_if.sv */
/*
   carrier between the supply/fault monitor and the motion controller.
   assumes both ends run on mclk.
*/
`timescale 1ns/1ps

interface fault_if;
   logic shutdown_cause;        // any cause of motor shutdown active
   logic internal_halt;         // internally generated immediate halt
   logic low_voltage_warning;   // battery below warning threshold

   // =========================================================
   // monitor drives, controller listens
   modport monitor (output shutdown_cause, output internal_halt, output low_voltage_warning);
   modport ctrl    (input  shutdown_cause, input  internal_halt, input  low_voltage_warning);
endinterface

/* fault_monitor.sv */
/*
   synchronises the asynchronous comparator and detector pins and turns
   them into shutdown cause, internal halt and low-voltage warning.
   assumes the pins are static levels from analog circuits, not mclk logic.
*/
`timescale 1ns/1ps

module fault_monitor (
   input  wire logic                          mclk,      // system clock
   input  wire logic                          rstn,      // async reset, active low
   input  wire logic [motion_pkg::MON_W-1:0]  mon_pins,  // raw monitor levels
   fault_if.monitor                           flt        // conditioned results
);

   // =========================================================
   // state
   motion_pkg::mon_state_t st;       // registered copy
   motion_pkg::mon_state_t next_st;  // next value

   // two stages; only the second stage is ever decoded
   always_comb begin
      next_st       = st;
      next_st.sync1 = mon_pins;
      next_st.sync2 = st.sync1;
   end

   // register the record
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st <= motion_pkg::MONS_RESET;
      end else begin
         st <= next_st;
      end
   end

   // =========================================================
   // decode of the synchronised levels
   // any of these forces shutdown
   assign flt.shutdown_cause = st.sync2[motion_pkg::MON_UV_SHUTDOWN] | st.sync2[motion_pkg::MON_THERMAL] |
                               st.sync2[motion_pkg::MON_ELEC_DEFECT] | st.sync2[motion_pkg::MON_PUMP_FAIL];
   // defect or overheating also raises the halt
   assign flt.internal_halt = st.sync2[motion_pkg::MON_ELEC_DEFECT] | st.sync2[motion_pkg::MON_THERMAL];
   // warning only, never a shutdown by itself
   assign flt.low_voltage_warning = st.sync2[motion_pkg::MON_UV_WARNING];

   // =========================================================
   // checks
   property p_warning_follows;
      @(posedge mclk) disable iff (!rstn)
         ##2 (flt.low_voltage_warning == $past(mon_pins[motion_pkg::MON_UV_WARNING], 2));
   endproperty
   a_warning_follows: assert property (p_warning_follows) else $error("warning does not track pin");

   property p_uv_shutdown_follows;
      @(posedge mclk) disable iff (!rstn)
         ##2 ($past(mon_pins[motion_pkg::MON_UV_SHUTDOWN], 2) |-> flt.shutdown_cause);
   endproperty
   a_uv_shutdown_follows: assert property (p_uv_shutdown_follows) else $error("undervoltage lost");

endmodule

/* motion_command_priority_fsm.sv */
/*
   motion state machine of the stepper controller: arbitrates decoded
   serial commands and internal events by priority, tracks the target
   position and drives bridge, hold current and ramp controls.
   assumes command strobes are one-cycle pulses from the serial decoder
   on mclk; ramp and position signals come from mclk logic; monitor pins
   are asynchronous.
*/
`timescale 1ns/1ps

// Summary of operation
// - undervoltage below shutdown threshold enters shutdown
// - below warning threshold raises low-voltage warning
// - command priority depends on state and flags
// - step loss blocks target and safe-position commands
// - halt from host or internal fault
// - starting a move enters moving-to-target state
// - moving exits only on halts, arrival or shutdown
// - immediate halt beats every other exit except shutdown
// - arrival acts only without any halt
// - shutdown entry: bridges off, target takes actual
// - leave shutdown on cleared causes plus status read
module motion_command_priority_fsm (
   input  wire logic                          mclk,                      // 100 MHz system clock
   input  wire logic                          rstn,                      // async reset, active low
   input  wire logic [motion_pkg::MON_W-1:0]  mon_pins,                  // async comparator levels
   input  wire logic                          cmd_set_target_position,   // set_target_position_cmd strobe
   input  wire logic                          cmd_goto_safe_position,    // goto_safe_position_cmd strobe
   input  wire logic                          cmd_immediate_halt,        // immediate_halt strobe
   input  wire logic                          cmd_decelerating_halt,     // decelerating_halt strobe
   input  wire logic                          cmd_reference_search,      // start reference search strobe
   input  wire logic                          cmd_read_status_one,       // read_status_one_cmd strobe
   input  wire logic [motion_pkg::POS_W-1:0]  cmd_position,              // position of set target command
   input  wire logic [motion_pkg::POS_W-1:0]  safe_position,             // programmed safe position
   input  wire logic [motion_pkg::POS_W-1:0]  actual_position_register,  // live motor position
   input  wire logic                          step_loss_flag,            // stall detected, level
   input  wire logic                          target_reached,            // ramp arrived at target
   input  wire logic                          ramp_speed_zero,           // ramp speed down to zero
   input  wire logic                          reference_done,            // reference search finished
   output logic      [2:0]                    motor_state,               // current motion state code
   output logic      [motion_pkg::POS_W-1:0]  target_position_register,  // current target
   output logic                               bridge_hi_z,               // h-bridges high impedance
   output logic                               hold_current,              // hold current in coils
   output logic                               ramp_run,                  // ramp drives toward target
   output logic                               ramp_decel,                // ramp decelerates to zero
   output logic                               low_voltage_warning        // battery below warning threshold
);

   // =========================================================
   // monitor instance
   fault_if flt ();                            // conditioned fault levels

   fault_monitor u_monitor (
      .mclk     (mclk),
      .rstn     (rstn),
      .mon_pins (mon_pins),
      .flt      (flt.monitor)
   );

   // =========================================================
   // state record and request terms
   motion_pkg::ctrl_state_t st;                // registered state
   motion_pkg::ctrl_state_t next_st;           // next value
   logic                    halt_req;          // host or internal halt
   logic                    pos_cmd_ok;        // positioning allowed

   // both halt sources share one path
   assign halt_req   = cmd_immediate_halt | flt.internal_halt;
   // positioning commands dropped while stalled
   assign pos_cmd_ok = ~step_loss_flag;

   // =========================================================
   // priority encoder; shutdown outranks everything
   always_comb begin
      next_st = st;
      if (flt.shutdown_cause) begin
         // copy only on entry so the target freezes inside
         if (st.state != motion_pkg::ST_SHUTDOWN) begin
            next_st.target = actual_position_register;
         end
         next_st.state = motion_pkg::ST_SHUTDOWN;
      end else begin
         case (st.state)
            motion_pkg::ST_STOPPED: begin
               if (halt_req) begin
                  next_st.state = motion_pkg::ST_IMMEDIATE_HALT;
               end else if (cmd_reference_search) begin
                  next_st.state = motion_pkg::ST_REFERENCE_SEARCH;
               end else if (cmd_set_target_position && pos_cmd_ok) begin
                  next_st.state  = motion_pkg::ST_MOVING_TO_TARGET;
                  next_st.target = cmd_position;
               end else if (cmd_goto_safe_position && pos_cmd_ok) begin
                  next_st.state  = motion_pkg::ST_MOVING_TO_TARGET;
                  next_st.target = safe_position;
               end
            end
            motion_pkg::ST_MOVING_TO_TARGET: begin
               // three exits, highest first
               if (halt_req) begin
                  next_st.state = motion_pkg::ST_IMMEDIATE_HALT;
               end else if (cmd_decelerating_halt) begin
                  next_st.state = motion_pkg::ST_DECELERATING_HALT;
               end else if (target_reached) begin
                  next_st.state = motion_pkg::ST_STOPPED;
               end else if (cmd_set_target_position && pos_cmd_ok) begin
                  // on-the-fly retarget, state unchanged
                  next_st.target = cmd_position;
               end else if (cmd_goto_safe_position && pos_cmd_ok) begin
                  next_st.target = safe_position;
               end
            end
            motion_pkg::ST_REFERENCE_SEARCH: begin
               // not interruptible except by halt or shutdown
               if (halt_req) begin
                  next_st.state = motion_pkg::ST_IMMEDIATE_HALT;
               end else if (reference_done) begin
                  next_st.state = motion_pkg::ST_STOPPED;
               end
            end
            motion_pkg::ST_DECELERATING_HALT: begin
               // ramp runs down, then hold current
               if (halt_req) begin
                  next_st.state = motion_pkg::ST_IMMEDIATE_HALT;
               end else if (ramp_speed_zero) begin
                  next_st.state = motion_pkg::ST_STOPPED;
               end
            end
            motion_pkg::ST_IMMEDIATE_HALT: begin
               // a status read releases the forced stop
               if (cmd_read_status_one && !halt_req) begin
                  next_st.state = motion_pkg::ST_STOPPED;
               end
            end
            motion_pkg::ST_SHUTDOWN: begin
               // causes already clear on this path
               if (cmd_read_status_one) begin
                  next_st.state = motion_pkg::ST_STOPPED;
               end
            end
            default: begin
               // unknown code: fail safe
               next_st.state = motion_pkg::ST_SHUTDOWN;
            end
         endcase
      end
   end

   // register the record
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st <= motion_pkg::CTRL_RESET;
      end else begin
         st <= next_st;
      end
   end

   // =========================================================
   // outputs, decoded from state flops
   assign motor_state              = st.state;
   assign target_position_register = st.target;
   // bridges floated only in shutdown
   assign bridge_hi_z              = (st.state == motion_pkg::ST_SHUTDOWN);
   assign hold_current             = (st.state == motion_pkg::ST_STOPPED);
   assign ramp_run                 = (st.state == motion_pkg::ST_MOVING_TO_TARGET) ||
                                     (st.state == motion_pkg::ST_REFERENCE_SEARCH);
   assign ramp_decel               = (st.state == motion_pkg::ST_DECELERATING_HALT);
   assign low_voltage_warning      = flt.low_voltage_warning;

   // =========================================================
   // checks
   sequence s_moving_quiet;
      (st.state == motion_pkg::ST_MOVING_TO_TARGET) && !flt.shutdown_cause && !halt_req;
   endsequence

   sequence s_enter_shutdown;
      (st.state != motion_pkg::ST_SHUTDOWN) ##1 (st.state == motion_pkg::ST_SHUTDOWN);
   endsequence

   property p_shutdown_entry;
      @(posedge mclk) disable iff (!rstn)
         flt.shutdown_cause |=> (st.state == motion_pkg::ST_SHUTDOWN) && bridge_hi_z;
   endproperty
   a_shutdown_entry: assert property (p_shutdown_entry) else $error("no shutdown on cause");

   property p_halt_first;
      @(posedge mclk) disable iff (!rstn)
         ((st.state == motion_pkg::ST_MOVING_TO_TARGET) && halt_req && !flt.shutdown_cause)
         |=> (st.state == motion_pkg::ST_IMMEDIATE_HALT);
   endproperty
   a_halt_first: assert property (p_halt_first) else $error("immediate halt lost priority");

   property p_decel_exit;
      @(posedge mclk) disable iff (!rstn)
         (s_moving_quiet and cmd_decelerating_halt) |=> (st.state == motion_pkg::ST_DECELERATING_HALT);
   endproperty
   a_decel_exit: assert property (p_decel_exit) else $error("decelerating halt not taken");

   property p_reached_last;
      @(posedge mclk) disable iff (!rstn)
         (s_moving_quiet and (!cmd_decelerating_halt && target_reached)) |=> hold_current;
   endproperty
   a_reached_last: assert property (p_reached_last) else $error("arrival not stopping");

   property p_moving_stays;
      @(posedge mclk) disable iff (!rstn)
         (s_moving_quiet and (!cmd_decelerating_halt && !target_reached)) |=> ramp_run && !ramp_decel;
   endproperty
   a_moving_stays: assert property (p_moving_stays) else $error("left moving without event");

   property p_step_loss_ignore;
      @(posedge mclk) disable iff (!rstn)
         (step_loss_flag && !flt.shutdown_cause) |=> $stable(target_position_register);
   endproperty
   a_step_loss_ignore: assert property (p_step_loss_ignore) else $error("target changed in step loss");

   property p_start_move;
      @(posedge mclk) disable iff (!rstn)
         ((st.state == motion_pkg::ST_STOPPED) && cmd_set_target_position && pos_cmd_ok &&
          !halt_req && !cmd_reference_search && !flt.shutdown_cause)
         |=> ramp_run && (target_position_register == $past(cmd_position));
   endproperty
   a_start_move: assert property (p_start_move) else $error("move not started");

   property p_shutdown_copy;
      @(posedge mclk) disable iff (!rstn)
         s_enter_shutdown |-> (target_position_register == $past(actual_position_register)) && bridge_hi_z;
   endproperty
   a_shutdown_copy: assert property (p_shutdown_copy) else $error("target not copied on shutdown");

   property p_shutdown_hold;
      @(posedge mclk) disable iff (!rstn)
         ((st.state == motion_pkg::ST_SHUTDOWN) && (flt.shutdown_cause || !cmd_read_status_one))
         |=> (st.state == motion_pkg::ST_SHUTDOWN);
   endproperty
   a_shutdown_hold: assert property (p_shutdown_hold) else $error("shutdown left early");

   property p_decel_done;
      @(posedge mclk) disable iff (!rstn)
         (ramp_decel && ramp_speed_zero && !halt_req && !flt.shutdown_cause) |=> hold_current && !ramp_decel;
   endproperty
   a_decel_done: assert property (p_decel_done) else $error("deceleration did not stop");

endmodule

/* host_model.sv */
/*
   stand-in for the host microcontroller: it issues decoded command
   strobes toward the motion state machine, one pulse per call.
   assumes the caller enters send at a falling edge of mclk.
*/
`timescale 1ns/1ps

module host_model (
   input  wire logic                          mclk,                     // system clock
   output logic                               cmd_set_target_position,  // set target strobe
   output logic                               cmd_goto_safe_position,   // safe position strobe
   output logic                               cmd_immediate_halt,       // immediate halt strobe
   output logic                               cmd_decelerating_halt,    // decelerating halt strobe
   output logic                               cmd_reference_search,     // reference search strobe
   output logic                               cmd_read_status_one,      // status read strobe
   output logic      [motion_pkg::POS_W-1:0]  cmd_position,             // position word
   output logic      [motion_pkg::POS_W-1:0]  safe_position             // programmed safe position
);
   // =========================================================
   // idle values at time zero
   initial begin
      {cmd_read_status_one, cmd_reference_search, cmd_decelerating_halt} = 3'h0;
      {cmd_immediate_halt, cmd_goto_safe_position, cmd_set_target_position} = 3'h0;
      cmd_position  = 16'h0000;
      safe_position = 16'h0000;
   end

   // =========================================================
   // one command cycle; several bits at once test arbitration
   // m: [0] set, [1] goto, [2] immediate halt [3] decel
   // [4] reference search, [5] status read
   task automatic send(input logic [5:0] m, input logic [15:0] pos, input logic [15:0] safe);
      {cmd_read_status_one, cmd_reference_search, cmd_decelerating_halt} <= m[5:3];
      {cmd_immediate_halt, cmd_goto_safe_position, cmd_set_target_position} <= m[2:0];
      cmd_position  <= pos;
      safe_position <= safe;
      @(negedge mclk);
      // strobes drop after one cycle; released position word shows the inverted word
      {cmd_read_status_one, cmd_reference_search, cmd_decelerating_halt} <= 3'h0;
      {cmd_immediate_halt, cmd_goto_safe_position, cmd_set_target_position} <= 3'h0;
      cmd_position <= ~pos;
      // idle edge, so the next call never re-drives a strobe in this step
      @(negedge mclk);
   endtask
endmodule

/* testbench.sv */
/*
   self-checking bench of the motion state machine: random command mixes
   against a priority model, plus shutdown, warning and power-up cases.
   assumes host_model.sv and the design files are compiled first.
*/
`timescale 1ns/1ps

module testbench;
   logic mclk = 1'b0;                         // 100 MHz clock
   logic rstn = 1'b0;                         // async reset, active low
   logic [4:0] mon_pins = 5'h00;              // monitor levels
   logic [15:0] act_pos = 16'h0000;           // actual position
   logic step_loss = 1'b0;                    // stall flag level
   logic treached = 1'b0;                     // ramp arrival
   logic rzero = 1'b0;                        // ramp speed zero
   wire c_set, c_goto, c_ih, c_dh, c_ref, c_rs1; // host strobes
   wire [15:0] c_pos, c_safe;                 // host data
   logic [2:0] motor_state;                   // observed state
   logic [15:0] tgt;                          // observed target
   logic bhz, hold, rrun, rdec, lvw;          // observed controls
   int miscompares = 0;                       // mismatch count
   int check_count = 0;                       // comparison count
   logic [2:0] cur, es;                       // state now / expected
   logic [15:0] et, p, s;                     // target expected, stimuli
   logic [5:0] m;                             // random command mix
   logic sl, tr;                              // random levels
   logic rdone = 1'b0;                        // reference search done

   always #5 mclk = ~mclk;

   host_model host_model_i (.mclk(mclk), .cmd_set_target_position(c_set), .cmd_goto_safe_position(c_goto),
      .cmd_immediate_halt(c_ih), .cmd_decelerating_halt(c_dh), .cmd_reference_search(c_ref),
      .cmd_read_status_one(c_rs1), .cmd_position(c_pos), .safe_position(c_safe));

   // design under test; the bench ends reference searches itself
   motion_command_priority_fsm motion_command_priority_fsm_i (.mclk(mclk), .rstn(rstn), .mon_pins(mon_pins),
      .cmd_set_target_position(c_set), .cmd_goto_safe_position(c_goto), .cmd_immediate_halt(c_ih),
      .cmd_decelerating_halt(c_dh), .cmd_reference_search(c_ref), .cmd_read_status_one(c_rs1),
      .cmd_position(c_pos), .safe_position(c_safe), .actual_position_register(act_pos),
      .step_loss_flag(step_loss), .target_reached(treached), .ramp_speed_zero(rzero), .reference_done(rdone),
      .motor_state(motor_state), .target_position_register(tgt), .bridge_hi_z(bhz), .hold_current(hold),
      .ramp_run(rrun), .ramp_decel(rdec), .low_voltage_warning(lvw));

   // =========================================================
   // expectation functions
   // next state by priority of state, flags and arrival
   function automatic logic [2:0] next_st(input logic [2:0] st, input logic [5:0] c, input logic l, input logic r);
      logic go;
      go = (c[0] | c[1]) & ~l;
      if (st == motion_pkg::ST_STOPPED) begin
         if (c[2]) return motion_pkg::ST_IMMEDIATE_HALT;
         else if (c[4]) return motion_pkg::ST_REFERENCE_SEARCH;
         else if (go) return motion_pkg::ST_MOVING_TO_TARGET;
         return st;
      end
      if (c[2]) return motion_pkg::ST_IMMEDIATE_HALT;
      else if (c[3]) return motion_pkg::ST_DECELERATING_HALT;
      else if (r) return motion_pkg::ST_STOPPED;
      return st;
   endfunction

   // target moves only when the winning event is a retarget
   function automatic logic [15:0] next_tg(input logic [2:0] st, input logic [5:0] c, input logic l,
                                           input logic r, input logic [15:0] q, input logic [15:0] sp,
                                           input logic [15:0] old);
      if (l | c[2] | (st == motion_pkg::ST_STOPPED & c[4])) return old;
      if (st != motion_pkg::ST_STOPPED & (c[3] | r)) return old;
      if (c[0]) return q;
      if (c[1]) return sp;
      return old;
   endfunction

   // control outputs {bridge_hi_z, hold, ramp_run, ramp_decel}
   function automatic logic [3:0] outs(input logic [2:0] st);
      case (st)
         motion_pkg::ST_SHUTDOWN:         return 4'h8;
         motion_pkg::ST_STOPPED:          return 4'h4;
         motion_pkg::ST_MOVING_TO_TARGET: return 4'h2;
         motion_pkg::ST_REFERENCE_SEARCH: return 4'h2;
         motion_pkg::ST_DECELERATING_HALT: return 4'h1;
         default:                         return 4'h0;
      endcase
   endfunction

   // =========================================================
   // comparison and verdict
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (miscompares == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // state plus its decoded controls in one go
   task automatic check_st(input logic [2:0] st);
      check({13'h0, motor_state}, {13'h0, st});
      check({12'h0, bhz, hold, rrun, rdec}, {12'h0, outs(st)});
   endtask

   // bring the machine back to stopped from any reachable state
   task automatic to_stopped(input logic [2:0] st);
      case (st)
         motion_pkg::ST_IMMEDIATE_HALT:   host_model_i.send(6'h20, p, s);
         motion_pkg::ST_DECELERATING_HALT: begin
            rzero = 1'b1;
            @(negedge mclk);
            rzero = 1'b0;
         end
         motion_pkg::ST_MOVING_TO_TARGET: begin
            @(negedge mclk);
            treached = 1'b1;
            @(negedge mclk);
            treached = 1'b0;
         end
         motion_pkg::ST_REFERENCE_SEARCH: begin
            host_model_i.send(6'h09, ~p, s);                     // set and decel do not break in
            check_st(motion_pkg::ST_REFERENCE_SEARCH);
            host_model_i.send(6'h01, ~p, s);
            if (p[0]) begin
               rdone = 1'b1;
               @(negedge mclk);
               rdone = 1'b0;
            end else begin
               host_model_i.send(6'h04, p, s);
               host_model_i.send(6'h20, p, s);
            end
         end
         default: ;
      endcase
      check_st(motion_pkg::ST_STOPPED);
      check(tgt, et);
   endtask

   // =========================================================
   // watchdog, about ten times the expected run length
   initial begin
      #200000;
      miscompares++;
      tally_and_finish();
   end

   // =========================================================
   // main sequence
   initial begin
      void'($urandom(32'h2B6A9DE4));
      repeat (10) @(negedge mclk);
      check_st(motion_pkg::ST_SHUTDOWN);
      rstn = 1'b1;
      @(negedge mclk);
      check_st(motion_pkg::ST_SHUTDOWN);
      host_model_i.send(6'h20, 16'h0000, 16'h0000);
      check_st(motion_pkg::ST_STOPPED);
      et = motion_pkg::TARGET_RESET;                            // reset target survives power-up
      // random mixes from stopped or moving
      repeat (300) begin
         @(negedge mclk);                                       // no level changes twice in one step
         p = 16'($urandom);
         s = 16'($urandom);
         cur = motion_pkg::ST_STOPPED;
         if ($urandom_range(1, 0) == 1) begin
            host_model_i.send(6'h01, p, s);
            cur = motion_pkg::ST_MOVING_TO_TARGET;
            et = p;
            check_st(cur);
         end
         m = 6'($urandom_range(31, 0));
         sl = ($urandom_range(3, 0) == 0);
         tr = (cur == motion_pkg::ST_MOVING_TO_TARGET) & 1'($urandom_range(1, 0));
         p = 16'($urandom);
         es = next_st(cur, m, sl, tr);
         et = next_tg(cur, m, sl, tr, p, s, et);
         step_loss = sl;
         treached = tr;
         host_model_i.send(m, p, s);
         step_loss = 1'b0;
         treached = 1'b0;
         check_st(es);
         check(tgt, et);
         to_stopped(es);
      end
      // warning alone keeps the motor stopped
      mon_pins = 5'h02;
      repeat (3) @(negedge mclk);
      check({15'h0, lvw}, 16'h0001);
      check_st(motion_pkg::ST_STOPPED);
      mon_pins = 5'h00;
      repeat (3) @(negedge mclk);
      check({15'h0, lvw}, 16'h0000);
      // each shutdown cause, from a moving motor
      for (int i = 0; i < 5; i++) begin
         if (i == 1) continue;
         host_model_i.send(6'h01, 16'h1234, s);
         act_pos = 16'($urandom);
         mon_pins = 5'h01 << i;
         repeat (3) @(negedge mclk);
         check_st(motion_pkg::ST_SHUTDOWN);
         check(tgt, act_pos);
         host_model_i.send(6'h21, 16'h4321, s);                  // read while cause still active
         check_st(motion_pkg::ST_SHUTDOWN);
         mon_pins = 5'h00;
         repeat (3) @(negedge mclk);
         host_model_i.send(6'h20, 16'h4321, s);
         check_st(motion_pkg::ST_STOPPED);
         check(tgt, act_pos);
      end
      tally_and_finish();
   end
endmodule
